//--- src/tocr_cfg.svh
// register offsets, field positions and reset values of the trace and overflow control bank
`ifndef TOCR_CFG_SVH
`define TOCR_CFG_SVH
`define TOCR_ADDR_OVF_CLEAR   12'h390
`define TOCR_ADDR_OUT_BASE    12'h560
`define TOCR_ADDR_OUT_PTRS    12'h561
`define TOCR_ADDR_CTL         12'h570
`define TOCR_ADDR_STATUS      12'h571
`define TOCR_ADDR_PGBASE      12'h572
`define TOCR_PHYS_WIDTH       8'h27
`define TOCR_CTL_EN           0
`define TOCR_CTL_SUPV         2
`define TOCR_CTL_USER         3
`define TOCR_CTL_PGFILT       7
`define TOCR_CTL_TABLE        8
`define TOCR_CTL_TSC          10
`define TOCR_CTL_RETDIS       11
`define TOCR_CTL_MUST1        13
`define TOCR_CTL_WMASK        64'h0000_0000_0000_2d8d
`define TOCR_STS_CTX          1
`define TOCR_STS_TRIG         2
`define TOCR_STS_ERR          4
`define TOCR_STS_STOP         5
`define TOCR_PTRS_WMASK       64'hffff_ffff_ffff_ff80
`define TOCR_PGBASE_WMASK     64'hffff_ffff_ffff_ffe0
`define TOCR_BASE_LSB         7
`define TOCR_OVF_GP_MASK      64'h0000_0000_0000_000f
`define TOCR_OVF_FIX_MASK     64'h0000_0007_0000_0000
`define TOCR_OVF_MISC_MASK    64'he080_0000_0000_0000
`define TOCR_RESET_VAL        64'h0000_0000_0000_0000
`endif

//--- src/tocr_flags.sv
// sticky status flags with per-bit hardware set and write-one clear
`default_nettype none
module tocr_flags
  import tocr_pkg::*;
#(
  parameter int W = 64
) (
  input  wire logic         core_clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flags_out
);
  // set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= (flags_out & ~clr_in) | set_in;
    end
  end
endmodule // tocr_flags
`default_nettype wire

//--- src/tocr_pkg.sv
// types shared by the trace and overflow control bank
`default_nettype none
package tocr_pkg;
  typedef logic [63:0] tocr_word_t;
  typedef enum logic [1:0] {
    TOCR_ACC_OK   = 2'h0,
    TOCR_ACC_FAULT = 2'h1
  } tocr_acc_t;
endpackage
`default_nettype wire

//--- src/tocr_regs.sv
// trace control and counter overflow-clear register bank
`include "tocr_cfg.svh"
`default_nettype none
module tocr_regs
  import tocr_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        acc_valid_in,     // one-cycle register access strobe
  input  wire logic        acc_write_in,     // 1 write, 0 read
  input  wire logic [11:0] acc_addr_in,      // register address
  input  wire logic [63:0] acc_wdata_in,     // write data
  input  wire logic [63:0] ovf_set_in,       // hardware sets of overflow flags
  input  wire logic        ctx_en_in,        // context enable state
  input  wire logic        trig_en_in,       // trigger enable state
  input  wire logic        stop_set_in,      // pulse: tracing stopped
  input  wire logic        err_set_in,       // pulse: tracing error
  input  wire logic [63:0] cur_pgbase_in,    // current page-table base
  output logic             acc_done_out,     // access answered
  output logic [63:0]      acc_rdata_out,    // read data
  output logic             gp_fault_out,     // general_protection_fault pulse
  output logic [63:0]      ovf_flags_out,    // overflow flag vector
  output logic [7:0]       phys_width_out,   // reported address width
  output logic             trace_active_out, // trace output permitted
  output logic [63:0]      ctl_out           // control register image
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic       wr;
  logic       rd;
  logic       bad_enable;
  tocr_word_t base_mask;
  tocr_word_t ovf_clr;
  tocr_word_t ovf_flags;
  tocr_word_t out_base_ff;
  tocr_word_t out_ptrs_ff;
  tocr_word_t ctl_ff;
  tocr_word_t pgbase_ff;
  logic       sts_err_ff;
  logic       sts_stop_ff;
  tocr_word_t rd_mux;
  logic       hit;

  assign wr = acc_valid_in & acc_write_in;
  assign rd = acc_valid_in & ~acc_write_in;
  // base field bounded by physical width
  assign base_mask = ((64'h1 << `TOCR_PHYS_WIDTH) - 64'h1) & ~((64'h1 << `TOCR_BASE_LSB) - 64'h1);
  // enable without table mode or bit 13 faults
  assign bad_enable = acc_wdata_in[`TOCR_CTL_EN] &
                      (~acc_wdata_in[`TOCR_CTL_TABLE] | ~acc_wdata_in[`TOCR_CTL_MUST1]);

  // ---------------------------------------------------------------
  // overflow flags, write-one clear
  // ---------------------------------------------------------------
  // write-one clear bits
  assign ovf_clr = (wr && acc_addr_in == `TOCR_ADDR_OVF_CLEAR) ?
                   (acc_wdata_in & (`TOCR_OVF_GP_MASK | `TOCR_OVF_FIX_MASK | `TOCR_OVF_MISC_MASK)) : '0;

  tocr_flags #(.W(64)) u_ovf (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .set_in      (ovf_set_in & (`TOCR_OVF_GP_MASK | `TOCR_OVF_FIX_MASK | `TOCR_OVF_MISC_MASK)),
    .clr_in      (ovf_clr),
    .flags_out   (ovf_flags)
  );
  assign ovf_flags_out = ovf_flags;

  // ---------------------------------------------------------------
  // trace registers
  // ---------------------------------------------------------------
  // address and pointer registers
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      out_base_ff <= `TOCR_RESET_VAL;
      out_ptrs_ff <= `TOCR_RESET_VAL;
      pgbase_ff   <= `TOCR_RESET_VAL;
    end else if (wr) begin
      if (acc_addr_in == `TOCR_ADDR_OUT_BASE) out_base_ff <= acc_wdata_in & base_mask;
      if (acc_addr_in == `TOCR_ADDR_OUT_PTRS) out_ptrs_ff <= acc_wdata_in & `TOCR_PTRS_WMASK;
      if (acc_addr_in == `TOCR_ADDR_PGBASE)   pgbase_ff   <= acc_wdata_in & `TOCR_PGBASE_WMASK;
    end
  end

  // control register, rejected write keeps old value
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctl_ff <= `TOCR_RESET_VAL;
    end else if (wr && acc_addr_in == `TOCR_ADDR_CTL && !bad_enable) begin
      ctl_ff <= acc_wdata_in & `TOCR_CTL_WMASK;
    end
  end

  // error and stopped: software writable, hardware set wins
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sts_err_ff  <= 1'b0;
      sts_stop_ff <= 1'b0;
    end else begin
      if (err_set_in) begin
        sts_err_ff <= 1'b1;
      end else if (wr && acc_addr_in == `TOCR_ADDR_STATUS) begin
        sts_err_ff <= acc_wdata_in[`TOCR_STS_ERR];
      end
      if (stop_set_in) begin
        sts_stop_ff <= 1'b1;
      end else if (wr && acc_addr_in == `TOCR_ADDR_STATUS) begin
        sts_stop_ff <= acc_wdata_in[`TOCR_STS_STOP];
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    hit    = 1'b1;
    unique case (acc_addr_in)
      `TOCR_ADDR_OVF_CLEAR: rd_mux = '0; // write-only
      `TOCR_ADDR_OUT_BASE:  rd_mux = out_base_ff;
      `TOCR_ADDR_OUT_PTRS:  rd_mux = out_ptrs_ff;
      `TOCR_ADDR_CTL:       rd_mux = ctl_ff;
      `TOCR_ADDR_STATUS: begin
        // context and trigger follow hardware only
        rd_mux[`TOCR_STS_CTX]  = ctx_en_in;
        rd_mux[`TOCR_STS_TRIG] = trig_en_in;
        rd_mux[`TOCR_STS_ERR]  = sts_err_ff;
        rd_mux[`TOCR_STS_STOP] = sts_stop_ff;
      end
      `TOCR_ADDR_PGBASE:    rd_mux = pgbase_ff;
      default:              hit = 1'b0;
    endcase
  end

  // access answer one cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      acc_done_out  <= 1'b0;
      acc_rdata_out <= '0;
      gp_fault_out  <= 1'b0;
    end else begin
      acc_done_out  <= acc_valid_in;
      acc_rdata_out <= (rd && hit) ? rd_mux : '0;
      gp_fault_out  <= acc_valid_in & (~hit | (wr & (acc_addr_in == `TOCR_ADDR_CTL) & bad_enable));
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      phys_width_out <= 8'h00;
      ctl_out        <= '0;
    end else begin
      phys_width_out <= `TOCR_PHYS_WIDTH;
      ctl_out        <= ctl_ff;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      trace_active_out <= 1'b0;
    end else begin
      trace_active_out <= ctl_ff[`TOCR_CTL_EN] & ~sts_stop_ff &
                          (~ctl_ff[`TOCR_CTL_PGFILT] |
                           ((cur_pgbase_in & `TOCR_PGBASE_WMASK) == pgbase_ff));
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // general counter clear
  a_ovf_clear_works: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_OVF_CLEAR && acc_wdata_in[0] && !ovf_set_in[0]) |=> !ovf_flags_out[0])
    else $error("counter 0 overflow not cleared");

  a_ovf_zero_keeps: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_OVF_CLEAR && !acc_wdata_in[3] && ovf_flags_out[3]) |=> ovf_flags_out[3])
    else $error("zero write cleared a flag");

  a_flag_set_wins: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ovf_set_in[0] |=> ovf_flags_out[0])
    else $error("overflow set lost to a clear");

  a_fixed_clear: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_OVF_CLEAR && acc_wdata_in[34] && !ovf_set_in[34]) |=> !ovf_flags_out[34])
    else $error("fixed counter 2 overflow not cleared");

  a_table_irq_clear: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_OVF_CLEAR && acc_wdata_in[55] && !ovf_set_in[55]) |=> !ovf_flags_out[55])
    else $error("table interrupt flag not cleared");

  a_cond_clear: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_OVF_CLEAR && acc_wdata_in[63] && !ovf_set_in[63]) |=> !ovf_flags_out[63])
    else $error("condition-changed flag not cleared");

  a_ovf_clear_all: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_OVF_CLEAR) |=>
      (ovf_flags_out & $past(acc_wdata_in) & ~$past(ovf_set_in)) == '0)
    else $error("overflow flag survived its clear");

  a_base_reserved: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (out_base_ff & ~base_mask) == '0)
    else $error("reserved output base bits set");

  a_width_report: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !$past(srst_in) |-> phys_width_out == `TOCR_PHYS_WIDTH)
    else $error("address width report wrong");

  a_ptrs_offsets: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_OUT_PTRS) |=> out_ptrs_ff == ($past(acc_wdata_in) & `TOCR_PTRS_WMASK))
    else $error("pointer fields stored wrongly");

  a_ctl_reserved: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (ctl_ff & ~`TOCR_CTL_WMASK) == '0)
    else $error("reserved control bits set");

  a_enable_fault: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_CTL && acc_wdata_in[0] && !acc_wdata_in[8]) |=> gp_fault_out && $stable(ctl_ff))
    else $error("enable without table mode accepted");

  a_bit13_fault: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_CTL && acc_wdata_in[0] && !acc_wdata_in[13]) |=> gp_fault_out)
    else $error("enable without bit 13 accepted");

  a_ctl_fields: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_CTL && !bad_enable) |=> ctl_ff[11:0] == ($past(acc_wdata_in[11:0]) & 12'hd8d))
    else $error("control fields stored wrongly");

  a_status_ignore: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (rd && acc_addr_in == `TOCR_ADDR_STATUS) |=>
      acc_rdata_out[`TOCR_STS_CTX] == $past(ctx_en_in) && acc_rdata_out[`TOCR_STS_TRIG] == $past(trig_en_in))
    else $error("context or trigger bit not from hardware");

  a_err_set_wins: assert property (@(posedge core_clk_in) disable iff (srst_in)
    err_set_in |=> sts_err_ff)
    else $error("error flag not set");

  a_stop_blocks: assert property (@(posedge core_clk_in) disable iff (srst_in)
    sts_stop_ff |=> !trace_active_out)
    else $error("trace active while stopped");

  a_pgbase_low: assert property (@(posedge core_clk_in) disable iff (srst_in)
    pgbase_ff[4:0] == 5'h00 && out_ptrs_ff[6:0] == 7'h00)
    else $error("reserved low bits set");

  a_pgbase_store: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (wr && acc_addr_in == `TOCR_ADDR_PGBASE) |=> pgbase_ff == ($past(acc_wdata_in) & `TOCR_PGBASE_WMASK))
    else $error("page base match stored wrongly");

  a_filter_gate: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (ctl_ff[7] && ((cur_pgbase_in & `TOCR_PGBASE_WMASK) != pgbase_ff)) |=> !trace_active_out)
    else $error("trace active on page base mismatch");

  // answer one cycle later
  a_done_pulse: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_done_out == $past(acc_valid_in))
    else $error("access answer not one cycle after strobe");

  // unmapped address faults
  a_unmapped_fault: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (acc_valid_in && !hit) |=> gp_fault_out && acc_rdata_out == '0)
    else $error("unmapped access not faulted");

  // read data idle zero
  a_rdata_idle: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !rd |=> acc_rdata_out == '0)
    else $error("read data shown without a read");
endmodule // tocr_regs
`default_nettype wire

//--- tb/tb_trace_and_overflow_ctrl_regs.sv
// self-checking bench for the trace and overflow control register bank
`include "tocr_cfg.svh"
`default_nettype none
`define CHK(nm, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("BAD %s exp %h got %h", nm, exp, got); \
  end \
end
module tb_trace_and_overflow_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        acc_valid = 1'b0;
  logic        acc_write = 1'b0;
  logic [11:0] acc_addr = 12'h000;
  logic [63:0] acc_wdata = 64'h0;
  logic [63:0] ovf_set = 64'h0;
  logic        ctx_en = 1'b1;
  logic        trig_en = 1'b0;
  logic        stop_set = 1'b0;
  logic        err_set = 1'b0;
  logic [63:0] cur_pgbase = 64'h0;
  logic        done, gpf, active;
  logic [63:0] rdata, flags, ctl;
  logic [7:0]  pwidth;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  tocr_regs tocr_regs_i (.core_clk_in(clk), .srst_in(srst), .acc_valid_in(acc_valid), .acc_write_in(acc_write),
    .acc_addr_in(acc_addr), .acc_wdata_in(acc_wdata), .ovf_set_in(ovf_set), .ctx_en_in(ctx_en),
    .trig_en_in(trig_en), .stop_set_in(stop_set), .err_set_in(err_set), .cur_pgbase_in(cur_pgbase),
    .acc_done_out(done), .acc_rdata_out(rdata), .gp_fault_out(gpf), .ovf_flags_out(flags),
    .phys_width_out(pwidth), .trace_active_out(active), .ctl_out(ctl));
  // ----------------------------------------
  // clock, timeout and closing report
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // register access: strobe one cycle, judge the answer
  // ----------------------------------------
  task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] d, input logic f, input logic [63:0] e);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    @(negedge clk);
    acc_valid = 1'b0;
    `CHK("done", 1'b1, done)
    `CHK("fault", f, gpf)
    if (!w) `CHK("rdata", e, rdata)
  endtask
  task automatic wr(input logic [11:0] a, input logic [63:0] d, input logic f);
    acc(1'b1, a, d, f, 64'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [63:0] e);
    acc(1'b0, a, 64'h0, 1'b0, e);
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_overflow();
    @(negedge clk);
    ovf_set = 64'hffff_ffff_ffff_ffff;
    @(negedge clk);
    ovf_set = 64'h0;
    `CHK("flags_set", 64'he080_0007_0000_000f, flags)
    wr(`TOCR_ADDR_OVF_CLEAR, 64'h0, 1'b0);
    `CHK("ovf_zero", 64'he080_0007_0000_000f, flags)
    wr(`TOCR_ADDR_OVF_CLEAR, 64'h5, 1'b0);
    `CHK("ovf_gp", 64'he080_0007_0000_000a, flags)
    wr(`TOCR_ADDR_OVF_CLEAR, 64'h0000_0005_0000_000a, 1'b0);
    `CHK("ovf_fix", 64'he080_0002_0000_0000, flags)
    wr(`TOCR_ADDR_OVF_CLEAR, 64'h0080_0000_0000_0000, 1'b0);
    `CHK("ovf_tbl", 64'he000_0002_0000_0000, flags)
    wr(`TOCR_ADDR_OVF_CLEAR, 64'ha000_0000_0000_0000, 1'b0);
    `CHK("ovf_misc", 64'h4000_0002_0000_0000, flags)
    wr(`TOCR_ADDR_OVF_CLEAR, 64'h4000_0002_0000_0000, 1'b0);
    `CHK("ovf_rest", 64'h0, flags)
    ovf_set = 64'h1;
    wr(`TOCR_ADDR_OVF_CLEAR, 64'h1, 1'b0);
    ovf_set = 64'h0;
    `CHK("ovf_setwin", 64'h1, flags)
    wr(`TOCR_ADDR_OVF_CLEAR, 64'h1, 1'b0);
    `CHK("ovf_clr0", 64'h0, flags)
    rd(`TOCR_ADDR_OVF_CLEAR, 64'h0);
  endtask
  task automatic t_addr_regs();
    rd(`TOCR_ADDR_OUT_BASE, 64'h0);
    `CHK("pwidth", 8'h27, pwidth)
    wr(`TOCR_ADDR_OUT_BASE, 64'hffff_ffff_ffff_ffff, 1'b0);
    rd(`TOCR_ADDR_OUT_BASE, 64'h0000_007f_ffff_ff80);
    wr(`TOCR_ADDR_OUT_PTRS, 64'hffff_ffff_ffff_ffff, 1'b0);
    rd(`TOCR_ADDR_OUT_PTRS, 64'hffff_ffff_ffff_ff80);
    wr(`TOCR_ADDR_PGBASE, 64'hffff_ffff_ffff_ffff, 1'b0);
    rd(`TOCR_ADDR_PGBASE, 64'hffff_ffff_ffff_ffe0);
    acc(1'b0, 12'h573, 64'h0, 1'b1, 64'h0);
  endtask
  task automatic t_control();
    wr(`TOCR_ADDR_CTL, 64'h0c8c, 1'b0);
    rd(`TOCR_ADDR_CTL, 64'h0c8c);
    wr(`TOCR_ADDR_CTL, 64'h2001, 1'b1);
    rd(`TOCR_ADDR_CTL, 64'h0c8c);
    wr(`TOCR_ADDR_CTL, 64'h0101, 1'b1);
    rd(`TOCR_ADDR_CTL, 64'h0c8c);
    wr(`TOCR_ADDR_CTL, 64'h2d8d, 1'b0);
    rd(`TOCR_ADDR_CTL, 64'h2d8d);
    `CHK("ctl_out", 64'h2d8d, ctl)
  endtask
  task automatic t_status();
    wr(`TOCR_ADDR_STATUS, 64'h36, 1'b0);
    rd(`TOCR_ADDR_STATUS, 64'h32);
    wr(`TOCR_ADDR_STATUS, 64'h0, 1'b0);
    rd(`TOCR_ADDR_STATUS, 64'h02);
    @(negedge clk);
    err_set = 1'b1;
    @(negedge clk);
    err_set = 1'b0;
    rd(`TOCR_ADDR_STATUS, 64'h12);
    wr(`TOCR_ADDR_STATUS, 64'h0, 1'b0);
    ctx_en = 1'b0;
    trig_en = 1'b1;
    rd(`TOCR_ADDR_STATUS, 64'h04);
    ctx_en = 1'b1;
    trig_en = 1'b0;
  endtask
  task automatic t_filter();
    cur_pgbase = 64'h1234_567f;
    wr(`TOCR_ADDR_PGBASE, 64'h1234_5678, 1'b0);
    wr(`TOCR_ADDR_CTL, 64'h2181, 1'b0);
    settle();
    `CHK("act_match", 1'b1, active)
    cur_pgbase = 64'h1234_5640;
    settle();
    `CHK("act_miss", 1'b0, active)
    wr(`TOCR_ADDR_CTL, 64'h2101, 1'b0);
    settle();
    `CHK("act_nofilt", 1'b1, active)
    stop_set = 1'b1;
    @(negedge clk);
    stop_set = 1'b0;
    settle();
    `CHK("act_stop", 1'b0, active)
    rd(`TOCR_ADDR_STATUS, 64'h22);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    t_addr_regs();
    t_overflow();
    t_control();
    t_status();
    t_filter();
    test_done();
  end
endmodule // tb_trace_and_overflow_ctrl_regs
`default_nettype wire
